//--- logic/bsfbm_map.vh
// Constants for the two-way bus-matching FIFO block
`ifndef BSFBM_MAP_VH
`define BSFBM_MAP_VH

`define BSFBM_DEPTH       9'h100
`define BSFBM_CNT_RST     9'h000
`define BSFBM_PTR_RST     8'h00

`define BSFBM_REG_CONFIG  8'h00
`define BSFBM_REG_OFFSETS 8'h04
`define BSFBM_REG_STATUS  8'h08

`define BSFBM_CFG_SIZE_LSB   0
`define BSFBM_CFG_ORDER_BIT  2
`define BSFBM_CFG_FALL_THROUGH_MODE_BIT   3
`define BSFBM_CFG_SERIAL_BIT 4
`define BSFBM_CFG_PROG_BIT   5
`define BSFBM_CFG_DONE_BIT   6
`define BSFBM_ST_CNT1_LSB    0
`define BSFBM_ST_CNT2_LSB    16
`define BSFBM_ST_MB1_BIT     28
`define BSFBM_ST_MB2_BIT     29

`define BSFBM_SZ_LONG     2'h0
`define BSFBM_SZ_WORD     2'h1
`define BSFBM_SZ_BYTE     2'h2

`define BSFBM_FS_64       2'h0
`define BSFBM_FS_8        2'h1
`define BSFBM_FS_16       2'h2
`define BSFBM_FS_PROG     2'h3
`define BSFBM_OFF_8       8'h08
`define BSFBM_OFF_16      8'h10
`define BSFBM_OFF_64      8'h40
`define BSFBM_OFF_RST     32'h40404040
`define BSFBM_SER_BITS    6'h20

`define BSFBM_FLAG_RST    4'h5

`endif

//--- logic/bsfbm_top.v
// Two-way 36-bit FIFO pair with port B bus matching and mailboxes
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "bsfbm_map.vh"

module bsfbm_top
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        master_reset_one_n,
    input  wire        master_reset_two_n,
    input  wire        partial_reset_one_n,
    input  wire        partial_reset_two_n,
    input  wire        byte_order_timing_select,
    input  wire        serial_program_select_n,
    input  wire        serial_offset_input,
    input  wire        serial_offset_strobe,
    input  wire        offset_select_low,
    input  wire        offset_select_high,
    input  wire [35:0] a_data_in,
    output wire [35:0] a_data_out,
    output wire        a_data_oe,
    input  wire        a_output_en,
    input  wire        a_write_en,
    input  wire        a_read_en,
    input  wire        a_mailbox_sel,
    input  wire [35:0] b_data_in,
    output wire [35:0] b_data_out,
    output wire        b_data_oe,
    input  wire        b_output_en,
    input  wire        b_write_en,
    input  wire        b_read_en,
    input  wire        b_mailbox_sel,
    output wire        port_a_output_ready,
    output wire        port_a_input_ready,
    output wire        port_a_almost_empty_n,
    output wire        port_a_almost_full_n,
    output wire        port_b_output_ready,
    output wire        port_b_input_ready,
    output wire        port_b_almost_empty_n,
    output wire        port_b_almost_full_n,
    output wire        mailbox_one_flag,
    output wire        mailbox_two_flag,
    output wire        low_power_idle
);

    function [1:0] last_idx;
        input [1:0] sz;
        begin
            case (sz)
                `BSFBM_SZ_WORD: last_idx = 2'h1;
                `BSFBM_SZ_BYTE: last_idx = 2'h3;
                default:        last_idx = 2'h0;
            endcase
        end
    endfunction

    function [35:0] width_mask;
        input [1:0] sz;
        begin
            case (sz)
                `BSFBM_SZ_WORD: width_mask = 36'h00003ffff;
                `BSFBM_SZ_BYTE: width_mask = 36'h0000001ff;
                default:        width_mask = 36'hfffffffff;
            endcase
        end
    endfunction

    // Big-endian puts the first piece in the most significant lane
    function [1:0] lane;
        input [1:0] idx;
        input [1:0] sz;
        input       be;
        begin
            lane = be ? (last_idx(sz) - idx) : idx;
        end
    endfunction

    function [35:0] piece_get;
        input [35:0] w;
        input [1:0]  idx;
        input [1:0]  sz;
        input        be;
        reg   [1:0]  p;
        begin
            p = lane(idx, sz, be);
            case (sz)
                `BSFBM_SZ_WORD: piece_get = {18'h00000, w[p[0]*18 +: 18]};
                `BSFBM_SZ_BYTE: piece_get = {27'h0000000, w[p*9 +: 9]};
                default:        piece_get = w;
            endcase
        end
    endfunction

    function [35:0] piece_put;
        input [35:0] acc;
        input [35:0] d;
        input [1:0]  idx;
        input [1:0]  sz;
        input        be;
        reg   [1:0]  p;
        begin
            p = lane(idx, sz, be);
            piece_put = acc;
            case (sz)
                `BSFBM_SZ_WORD: piece_put[p[0]*18 +: 18] = d[17:0];
                `BSFBM_SZ_BYTE: piece_put[p*9 +: 9] = d[8:0];
                default:        piece_put = d;
            endcase
        end
    endfunction

    function [7:0] default_off;
        input [1:0] fs;
        begin
            case (fs)
                `BSFBM_FS_8:  default_off = `BSFBM_OFF_8;
                `BSFBM_FS_16: default_off = `BSFBM_OFF_16;
                default:      default_off = `BSFBM_OFF_64;
            endcase
        end
    endfunction

    reg  [1:0]  size_q;
    reg         be_q;
    reg  [1:0]  fs_q;
    reg         serial_q;
    reg  [5:0]  ser_cnt_q;
    reg  [31:0] off_q;
    reg  [35:0] mb1_q;
    reg  [35:0] mb2_q;
    reg         mb1_flag_q;
    reg         mb2_flag_q;
    reg  [1:0]  bw_idx_q;
    reg  [35:0] bw_acc_q;
    reg  [1:0]  br_idx_q;
    reg         idle_q;
    reg         ahb_wr_q;
    reg  [7:0]  ahb_addr_q;
    reg  [31:0] hrdata_q;

    wire [1:0]  clr;
    wire [1:0]  wr_req;
    wire [1:0]  rd_req;
    wire [71:0] wr_word;
    wire [71:0] out_word;
    wire [1:0]  out_valid;
    wire [1:0]  full;
    wire [17:0] cnt;
    wire [7:0]  flags;
    wire [15:0] ae_off;
    wire [15:0] af_off;
    wire        fall_through_mode;
    wire        mrs_any;
    wire        prog;
    wire        ser_shift;
    wire        ahb_take;
    wire        ahb_wr_ok;
    wire        b_fifo_wr;
    wire        b_fifo_rd;
    wire [1:0]  b_last;
    wire [35:0] bw_next;
    wire        mb1_set;
    wire        mb1_clr;
    wire        mb2_set;
    wire        mb2_clr;

    assign mrs_any = ~master_reset_one_n | ~master_reset_two_n;
    assign fall_through_mode    = byte_order_timing_select;
    assign clr[0]  = ~master_reset_one_n | ~partial_reset_one_n;
    assign clr[1]  = ~master_reset_two_n | ~partial_reset_two_n;
    assign ae_off  = {off_q[15:8], off_q[31:24]};
    assign af_off  = {off_q[7:0], off_q[23:16]};

    // FIFO 0 carries A to B, FIFO 1 carries B to A
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_fifo
            reg [35:0] mem [0:255];
            reg [7:0]  wp_q;
            reg [7:0]  rp_q;
            reg [8:0]  cnt_q;
            reg [35:0] out_q;
            reg        ov_q;
            reg [3:0]  s1_q;
            reg [3:0]  s2_q;
            wire       is_full;
            wire       push;
            wire       load;
            wire [8:0] free;
            wire [3:0] raw;

            assign is_full = (cnt_q == `BSFBM_DEPTH);
            assign push    = wr_req[i] & ~is_full;
            // A word written this edge is not yet countable, so never read
            assign load = (rd_req[i] | (fall_through_mode & ~ov_q)) &
                          (cnt_q != `BSFBM_CNT_RST);
            assign free = `BSFBM_DEPTH - cnt_q;

            always @(posedge hclk)
            begin
                if (push)
                    mem[wp_q] <= wr_word[i*36 +: 36];
            end

            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    wp_q  <= `BSFBM_PTR_RST;
                    rp_q  <= `BSFBM_PTR_RST;
                    cnt_q <= `BSFBM_CNT_RST;
                    out_q <= 36'h000000000;
                    ov_q  <= 1'b0;
                end
                else if (clr[i])
                begin
                    wp_q  <= `BSFBM_PTR_RST;
                    rp_q  <= `BSFBM_PTR_RST;
                    cnt_q <= `BSFBM_CNT_RST;
                    ov_q  <= 1'b0;
                end
                else
                begin
                    if (push)
                        wp_q <= wp_q + 8'h01;
                    if (load)
                    begin
                        rp_q  <= rp_q + 8'h01;
                        out_q <= mem[rp_q];
                    end
                    cnt_q <= cnt_q + {8'h00, push} - {8'h00, load};
                    if (load)
                        ov_q <= 1'b1;
                    else if (rd_req[i])
                        ov_q <= 1'b0;
                end
            end

            // Order: output ready, input ready, almost empty, almost full
            assign raw[3] = fall_through_mode ? ov_q : (cnt_q != `BSFBM_CNT_RST);
            assign raw[2] = ~is_full;
            assign raw[1] = (cnt_q > {1'b0, ae_off[i*8 +: 8]});
            assign raw[0] = (free > {1'b0, af_off[i*8 +: 8]});

            // Single clock here, so the write- and read-side chains share it
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_q <= `BSFBM_FLAG_RST;
                    s2_q <= `BSFBM_FLAG_RST;
                end
                else
                begin
                    s1_q <= raw;
                    s2_q <= s1_q;
                end
            end

            assign out_word[i*36 +: 36] = out_q;
            assign out_valid[i]         = ov_q;
            assign full[i]              = is_full;
            assign cnt[i*9 +: 9]        = cnt_q;
            assign flags[i*4 +: 4]      = s2_q;
        end
    endgenerate

    assign port_b_output_ready   = flags[3];
    assign port_a_input_ready    = flags[2];
    assign port_b_almost_empty_n = flags[1];
    assign port_a_almost_full_n  = flags[0];
    assign port_a_output_ready   = flags[7];
    assign port_b_input_ready    = flags[6];
    assign port_a_almost_empty_n = flags[5];
    assign port_b_almost_full_n  = flags[4];

    // Port A side, full width except mailbox one writes, which are masked to the port B size
    assign wr_req[0]        = a_write_en & ~a_mailbox_sel;
    assign wr_word[35:0]    = a_data_in;
    assign rd_req[1]        = a_read_en & ~a_mailbox_sel;
    assign a_data_out       = a_mailbox_sel ? mb2_q : out_word[71:36];
    assign a_data_oe        = a_output_en;

    // Port B side, packing and unpacking narrow pieces
    assign b_last    = last_idx(size_q);
    assign b_fifo_wr = b_write_en & ~b_mailbox_sel & ~full[1];
    assign bw_next   = piece_put(bw_acc_q, b_data_in, bw_idx_q,
                                 size_q, be_q);
    assign wr_req[1] = b_fifo_wr & (bw_idx_q == b_last);
    assign wr_word[71:36] = bw_next;
    assign b_fifo_rd = b_read_en & ~b_mailbox_sel;
    assign rd_req[0] = b_fifo_rd & (~out_valid[0] | (br_idx_q == b_last));
    assign b_data_out = b_mailbox_sel ? mb1_q :
                        piece_get(out_word[35:0], br_idx_q, size_q, be_q);
    assign b_data_oe = b_output_en;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bw_idx_q <= 2'h0;
            bw_acc_q <= 36'h000000000;
            br_idx_q <= 2'h0;
        end
        else
        begin
            if (clr[1])
                bw_idx_q <= 2'h0;
            else if (b_fifo_wr)
            begin
                bw_acc_q <= bw_next;
                bw_idx_q <= wr_req[1] ? 2'h0 : bw_idx_q + 2'h1;
            end
            if (clr[0])
                br_idx_q <= 2'h0;
            else if (b_fifo_rd)
                br_idx_q <= rd_req[0] ? 2'h0 : br_idx_q + 2'h1;
        end
    end

    // Mailboxes; a write into a full mailbox is dropped
    assign mb1_set = a_write_en & a_mailbox_sel & ~mb1_flag_q;
    assign mb1_clr = b_read_en & b_mailbox_sel;
    assign mb2_set = b_write_en & b_mailbox_sel & ~mb2_flag_q;
    assign mb2_clr = a_read_en & a_mailbox_sel;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mb1_q      <= 36'h000000000;
            mb2_q      <= 36'h000000000;
            mb1_flag_q <= 1'b0;
            mb2_flag_q <= 1'b0;
        end
        else
        begin
            if (mb1_set)
                mb1_q <= a_data_in & width_mask(size_q);
            if (mb2_set)
                mb2_q <= b_data_in & width_mask(size_q);
            if (!master_reset_one_n)
                mb1_flag_q <= 1'b0;
            else if (mb1_set)
                mb1_flag_q <= 1'b1;
            else if (mb1_clr)
                mb1_flag_q <= 1'b0;
            if (!master_reset_two_n)
                mb2_flag_q <= 1'b0;
            else if (mb2_set)
                mb2_flag_q <= 1'b1;
            else if (mb2_clr)
                mb2_flag_q <= 1'b0;
        end
    end

    assign mailbox_one_flag = mb1_flag_q;
    assign mailbox_two_flag = mb2_flag_q;

    // Configuration and offsets
    assign prog      = (fs_q == `BSFBM_FS_PROG);
    assign ser_shift = prog & serial_q & ~mrs_any & serial_offset_strobe &
                       (ser_cnt_q != `BSFBM_SER_BITS);
    assign ahb_take  = hsel & htrans[1] & hready;
    assign ahb_wr_ok = ahb_wr_q;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            size_q    <= `BSFBM_SZ_LONG;
            be_q      <= 1'b0;
            fs_q      <= `BSFBM_FS_64;
            serial_q  <= 1'b0;
            ser_cnt_q <= 6'h00;
            off_q     <= `BSFBM_OFF_RST;
        end
        else
        begin
            if (mrs_any)
            begin
                be_q      <= byte_order_timing_select;
                fs_q      <= {offset_select_high, offset_select_low};
                serial_q  <= ~serial_program_select_n;
                ser_cnt_q <= 6'h00;
            end
            else if (ser_shift)
                ser_cnt_q <= ser_cnt_q + 6'h01;
            if (!master_reset_one_n)
                off_q[31:16] <= {2{default_off(
                    {offset_select_high, offset_select_low})}};
            if (!master_reset_two_n)
                off_q[15:0] <= {2{default_off(
                    {offset_select_high, offset_select_low})}};
            if (ser_shift)
                off_q <= {off_q[30:0], serial_offset_input};
            else if (ahb_wr_ok && ahb_addr_q == `BSFBM_REG_OFFSETS &&
                     prog && !serial_q && !mrs_any)
                off_q <= hwdata;
            if (ahb_wr_ok && ahb_addr_q == `BSFBM_REG_CONFIG)
                size_q <= hwdata[`BSFBM_CFG_SIZE_LSB +: 2];
        end
    end

    // Zero-wait slave: read data is captured in the address phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= 8'h00;
            hrdata_q   <= 32'h00000000;
        end
        else
        begin
            ahb_wr_q   <= ahb_take & hwrite & (hsize == 3'h2) &
                          (haddr[31:8] == 24'h000000);
            ahb_addr_q <= haddr[7:0];
            if (ahb_take && !hwrite)
            begin
                hrdata_q <= 32'h00000000;
                if (haddr[31:8] == 24'h000000)
                begin
                    case (haddr[7:0])
                        `BSFBM_REG_CONFIG:
                            hrdata_q <= {25'h0000000,
                                ser_cnt_q == `BSFBM_SER_BITS, prog,
                                serial_q, fall_through_mode, be_q, size_q};
                        `BSFBM_REG_OFFSETS:
                            hrdata_q <= off_q;
                        `BSFBM_REG_STATUS:
                            hrdata_q <= {2'h0, mb2_flag_q, mb1_flag_q,
                                3'h0, cnt[17:9], 7'h00, cnt[8:0]};
                        default:
                            hrdata_q <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Idle drops out at once for a port enable or bus transfer, one edge later for the strobe and the resets
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            idle_q <= 1'b0;
        else
            idle_q <= ~(a_write_en | a_read_en | b_write_en | b_read_en |
                        serial_offset_strobe | mrs_any | ahb_take |
                        ~partial_reset_one_n | ~partial_reset_two_n);
    end

    assign low_power_idle = idle_q & ~(a_write_en | a_read_en |
                            b_write_en | b_read_en | ahb_take);

endmodule // bsfbm_top

//--- verification/bsfbm_chk_sva.sv
// Assertion checker for the bus-matching FIFO block
`timescale 1ns/1ps
module bsfbm_chk
(
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire a_write_en,
    input wire a_read_en,
    input wire a_mailbox_sel,
    input wire a_output_en,
    input wire a_data_oe,
    input wire b_write_en,
    input wire b_read_en,
    input wire b_mailbox_sel,
    input wire byte_order_timing_select,
    input wire master_reset_one_n,
    input wire partial_reset_one_n,
    input wire port_a_input_ready,
    input wire port_b_output_ready,
    input wire port_b_almost_empty_n,
    input wire port_a_almost_full_n,
    input wire mailbox_one_flag,
    input wire low_power_idle
);
    wire wa = a_write_en & ~a_mailbox_sel;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ahb_ok; hreadyout && !hresp; endproperty
    a_ahb_ok: assert property (p_ahb_ok)
        else $error("bus answer not ready or not okay");
    property p_mb_set;
        !mailbox_one_flag && a_write_en && a_mailbox_sel &&
            master_reset_one_n |=> mailbox_one_flag;
    endproperty
    a_mb_set: assert property (p_mb_set)
        else $error("mail flag did not set");
    property p_mb_clr;
        b_read_en && b_mailbox_sel && !(a_write_en && a_mailbox_sel)
            |=> !mailbox_one_flag;
    endproperty
    a_mb_clr: assert property (p_mb_clr)
        else $error("mail flag did not clear");
    property p_oe; a_data_oe == a_output_en; endproperty
    a_oe: assert property (p_oe)
        else $error("port a enable wrong");
    // Flag may only move two or three edges after the write that caused it
    property p_full_sync;
        $fell(port_a_input_ready) |-> $past(wa, 2) || $past(wa, 3);
    endproperty
    a_full_sync: assert property (p_full_sync)
        else $error("input ready fell without a write");
    property p_or_sync;
        $rose(port_b_output_ready) && !byte_order_timing_select
            |-> $past(wa, 2) || $past(wa, 3);
    endproperty
    a_or_sync: assert property (p_or_sync)
        else $error("output ready rose without a write");
    property p_mrst;
        !master_reset_one_n [*3] |=> !port_b_output_ready
            && port_a_input_ready && !mailbox_one_flag;
    endproperty
    a_mrst: assert property (p_mrst)
        else $error("master reset left state");
    property p_prst;
        !partial_reset_one_n [*3] |=> !port_b_output_ready
            && !port_b_almost_empty_n;
    endproperty
    a_prst: assert property (p_prst)
        else $error("partial reset did not flush");
    property p_ae;
        !port_b_output_ready && !byte_order_timing_select
            |-> !port_b_almost_empty_n;
    endproperty
    a_ae: assert property (p_ae)
        else $error("almost empty high while empty");
    property p_af;
        !port_a_input_ready |-> !port_a_almost_full_n;
    endproperty
    a_af: assert property (p_af)
        else $error("almost full high while full");
    property p_idle;
        a_write_en || a_read_en || b_write_en || b_read_en |-> !low_power_idle;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle while enabled");
    c_mb: cover property (mailbox_one_flag ##1 !mailbox_one_flag);
    c_rd: cover property (b_read_en && port_b_output_ready);
    c_pr: cover property (!partial_reset_one_n);
    c_full: cover property ($fell(port_a_input_ready));
endmodule // bsfbm_chk

bind bsfbm_top bsfbm_chk chk_u (.hclk, .hresetn, .hreadyout, .hresp,
    .a_write_en, .a_read_en, .a_mailbox_sel, .a_output_en, .a_data_oe,
    .b_write_en, .b_read_en, .b_mailbox_sel, .byte_order_timing_select,
    .master_reset_one_n, .partial_reset_one_n, .port_a_input_ready,
    .port_b_output_ready, .port_b_almost_empty_n, .mailbox_one_flag,
    .low_power_idle, .port_a_almost_full_n);

//--- verification/bsfbm_b_model.sv
// Port B far-side agent: drains FIFO1 and mailbox one, fills FIFO2
`timescale 1ns/1ps
module bsfbm_b_model
(
    input  wire        hclk,
    input  wire        rd_on,
    input  wire        wr_go,
    input  wire [35:0] wr_base,
    input  wire        port_b_output_ready,
    input  wire        port_b_input_ready,
    input  wire        mailbox_one_flag,
    output logic [35:0] b_data_in,
    output logic       b_write_en,
    output logic       b_read_en,
    output logic       b_mailbox_sel,
    output logic       b_output_en
);
    logic [2:0] gap;
    logic [1:0] sent;
    initial
    begin
        {b_data_in, b_write_en, b_read_en, b_mailbox_sel} = 39'h0;
        b_output_en = 1'b0;
        gap = 3'h0;
        sent = 2'h0;
    end
    always @(posedge hclk)
    begin
        b_read_en <= 1'b0;
        b_mailbox_sel <= 1'b0;
        b_write_en <= 1'b0;
        b_output_en <= rd_on;
        b_data_in <= ~b_data_in; // Released bus must not look held
        // Gap of three or more lets the synchronised flags catch up
        if (gap != 3'h0)
            gap <= gap - 3'h1;
        else if (rd_on && (mailbox_one_flag || port_b_output_ready))
        begin
            b_read_en <= 1'b1;
            b_mailbox_sel <= mailbox_one_flag;
            gap <= 3'h3 + 3'($urandom_range(3));
        end
        if (!wr_go)
            sent <= 2'h0;
        else if (sent < 2'h2 && port_b_input_ready)
        begin
            b_write_en <= 1'b1;
            b_data_in <= wr_base + 36'(sent);
            sent <= sent + 2'h1;
        end
    end
endmodule // bsfbm_b_model

//--- verification/bsfbm_top_test.sv
// Self-checking bench for the bus-matching FIFO block
`timescale 1ns/1ps
module bsfbm_top_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_on = 0, wr_go = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic master_reset_one_n = 0, master_reset_two_n = 0;
    logic partial_reset_one_n = 1, partial_reset_two_n = 1;
    logic serial_offset_input = 0, a_output_en = 0, a_write_en = 0;
    logic a_read_en = 0, a_mailbox_sel = 0, fall_through_mode = 0;
    logic [35:0] a_data_in = 0, wr_base = 0, b_data_in, d;
    wire [35:0] a_data_out, b_data_out;
    wire [31:0] hrdata;
    wire hreadyout, b_write_en, b_read_en, b_mailbox_sel, b_output_en;
    wire port_b_output_ready, port_b_input_ready, mailbox_one_flag;
    int error_cnt = 0, n_checks = 0;
    logic [35:0] qa[$], qb[$];
    logic [31:0] qh[$];
    logic ar_q = 0, ra_q = 0, rb_q = 0;
    bsfbm_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
        .master_reset_one_n, .master_reset_two_n, .partial_reset_one_n,
        .partial_reset_two_n, .byte_order_timing_select(fall_through_mode),
        .serial_program_select_n(1'b1), .serial_offset_input,
        .serial_offset_strobe(1'b0), .offset_select_low(1'b0),
        .offset_select_high(1'b0), .a_data_in, .a_data_out, .a_data_oe(),
        .a_output_en, .a_write_en, .a_read_en, .a_mailbox_sel, .b_data_in,
        .b_data_out, .b_data_oe(), .b_output_en, .b_write_en, .b_read_en,
        .b_mailbox_sel, .port_a_output_ready(), .port_a_input_ready(),
        .port_a_almost_empty_n(), .port_a_almost_full_n(),
        .port_b_output_ready, .port_b_input_ready, .port_b_almost_empty_n(),
        .port_b_almost_full_n(), .mailbox_one_flag, .mailbox_two_flag(),
        .low_power_idle());
    bsfbm_b_model far_u (.hclk, .rd_on, .wr_go, .wr_base,
        .port_b_output_ready, .port_b_input_ready, .mailbox_one_flag,
        .b_data_in, .b_write_en, .b_read_en, .b_mailbox_sel, .b_output_en);
    always #50 hclk = ~hclk;
    task automatic chk(string n, logic [35:0] s, logic [35:0] e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic ahb(logic w, logic [31:0] a, logic [31:0] v);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        if (!w)
            qh.push_back(v);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr_a(logic mb, logic [35:0] v);
        @(posedge hclk);
        a_write_en <= 1'b1;
        a_mailbox_sel <= mb;
        a_data_in <= v;
        @(posedge hclk);
        a_write_en <= 1'b0;
        a_mailbox_sel <= 1'b0;
        a_data_in <= ~v;
    endtask
    task automatic rd_a;
        @(posedge hclk);
        a_read_en <= 1'b1;
        @(posedge hclk);
        a_read_en <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    always @(posedge hclk)
    begin
        ar_q <= hsel && htrans[1] && !hwrite;
        ra_q <= a_read_en && !a_mailbox_sel;
        rb_q <= b_read_en && !b_mailbox_sel;
        serial_offset_input <= 1'($urandom);
    end
    always @(negedge hclk)
    begin
        if (ar_q)
            chk("hrdata", 36'(hrdata), 36'(qh.pop_front()));
        if (ra_q)
            chk("port a data", a_data_out, qa.pop_front());
        if (rb_q)
            chk("port b data", b_data_out, qb.pop_front());
        if (b_read_en && b_mailbox_sel)
            chk("mailbox", b_data_out, qb.pop_front());
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        error_cnt++;
        finish_test;
    end
    initial
    begin
        void'($urandom(32'hedcb892d));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        master_reset_one_n <= 1'b1;
        master_reset_two_n <= 1'b1;
        a_output_en <= 1'b1;
        ahb(0, 32'h0, 32'h0);
        ahb(0, 32'h4, 32'h40404040);
        ahb(0, 32'hc, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            d = 36'({$urandom, $urandom});
            qb.push_back(d);
            wr_a(1'b0, d);
        end
        repeat (4) @(posedge hclk);
        ahb(0, 32'h8, 32'h3);
        rd_on <= 1'b1;
        d = 36'({$urandom, $urandom});
        wr_base <= d;
        qa.push_back(d);
        qa.push_back(d + 36'h1);
        wr_go <= 1'b1;
        repeat (40) @(posedge hclk);
        rd_a();
        rd_a();
        wr_go <= 1'b0;
        rd_on <= 1'b0;
        wr_a(1'b0, 36'h123456789);
        wr_a(1'b0, 36'h0aaaaaaaa);
        partial_reset_two_n <= 1'b0;
        repeat (3) @(posedge hclk);
        partial_reset_two_n <= 1'b1;
        repeat (3) @(posedge hclk);
        ahb(0, 32'h8, 32'h2);
        a_write_en <= 1'b1;
        repeat (260) @(posedge hclk);
        a_write_en <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb(0, 32'h8, 32'h100);
        partial_reset_one_n <= 1'b0;
        repeat (3) @(posedge hclk);
        partial_reset_one_n <= 1'b1;
        repeat (3) @(posedge hclk);
        ahb(0, 32'h8, 32'h0);
        fall_through_mode <= 1'b1;
        d = 36'({$urandom, $urandom});
        wr_a(1'b0, d);
        repeat (4) @(posedge hclk);
        chk("fall through", b_data_out, d);
        chk("output ready", 36'(port_b_output_ready), 36'h1);
        fall_through_mode <= 1'b0;
        ahb(1, 32'h0, 32'h2);
        ahb(0, 32'h0, 32'h2);
        d = 36'({$urandom, $urandom});
        qb.push_back(d & 36'h1ff);
        rd_on <= 1'b1;
        wr_a(1'b1, d);
        repeat (12) @(posedge hclk);
        chk("pending", 36'(qa.size() + qb.size() + qh.size()), 36'h0);
        finish_test;
    end
endmodule // bsfbm_top_test
